// ===== adsc_cfg.svh
// constants for the converter sequencer: mode fields, timing counts
// assumes a 40 MHz system clock; included by the package, the engine and the sequencer
//
// Notes on behaviour
// - on conversion end, store result and pulse the end interrupt together
// - software start repeats conversions back to back while run bit is set
// - hardware start waits for a fresh trigger edge after each conversion
// - mode or channel write aborts a conversion; software start restarts it if run bit stays set, hardware start waits for a trigger edge
// - standby halts conversion; clearing run bit switches off the reference string
// - a result read in the store cycle returns the old value, then stores
// - trigger edges are ignored during conversion, including the store cycle
// - register write in the store cycle wins: no store and no interrupt
// - writing the channel select register leaves the end flag alone
// - a conversion ending just before a channel write still stores and flags
// - the input is sampled for about one tenth of the conversion time
// - the eight analog inputs double as a digital input port
// - each conversion yields a 10-bit result for the selected channel
`ifndef ADSC_CFG_SVH
`define ADSC_CFG_SVH

// ------------------------------------------------------------
// mode register fields
// ------------------------------------------------------------
`define ADSC_MODE_RUN      7
`define ADSC_MODE_TRIG     6
`define ADSC_MODE_EDGE_HI  2
`define ADSC_MODE_EDGE_LO  1
`define ADSC_MODE_POWER    0
`define ADSC_MODE_RESET    8'h00
`define ADSC_EDGE_FALL     2'h0
`define ADSC_EDGE_RISE     2'h1

// ------------------------------------------------------------
// widths, reset values and timing
// ------------------------------------------------------------
`define ADSC_RES_BITS      10
`define ADSC_NUM_CH        8
`define ADSC_RESULT_RESET  10'h000
`define ADSC_CHAN_RESET    3'h0
`define ADSC_SAMPLE_CYC    2
`define ADSC_BIT_CYC       2
`define ADSC_CLK_NS        25
`define ADSC_SETTLE_NS     14000
`define ADSC_SETTLE_CYC    ((`ADSC_SETTLE_NS + `ADSC_CLK_NS - 1) / `ADSC_CLK_NS)

`endif

// ===== adsc_pkg.sv
// types shared by the converter sequencer and its approximation engine
// assumes adsc_cfg.svh is on the include path
`include "adsc_cfg.svh"

package adsc_pkg;

    // ------------------------------------------------------------
    // sequencer states, one-hot
    // ------------------------------------------------------------
    typedef enum logic [2:0] {
        ST_IDLE = 3'b001,
        ST_WAIT = 3'b010,
        ST_CONV = 3'b100
    } adsc_state_type;

    // ------------------------------------------------------------
    // approximation engine phases, one-hot
    // ------------------------------------------------------------
    typedef enum logic [2:0] {
        PH_IDLE   = 3'b001,
        PH_SAMPLE = 3'b010,
        PH_BITS   = 3'b100
    } adsc_phase_type;

    typedef struct packed {
        adsc_phase_type ph;
        logic [3:0]     cnt;
        logic [3:0]     bit_idx;
        logic [9:0]     trial;
        logic [9:0]     result;
        logic           done;
    } adsc_sar_type;

    typedef struct packed {
        adsc_state_type st;
        logic [7:0]     mode;
        logic [2:0]     chan;
        logic [9:0]     result;
        logic [9:0]     rd_data;
        logic           flag;
        logic           irq;
        logic           trig_prev;
        logic [7:0]     port;
        logic [9:0]     settle_cnt;
        logic           settled;
    } adsc_ctl_type;

endpackage

// ===== adsc_sar.sv
// successive-approximation engine: sample phase, then one trial per bit
// assumes an external comparator answers cmp_in for the trial code shown
`timescale 1ns/1ps
`include "adsc_cfg.svh"

module adsc_sar
    import adsc_pkg::*;
#(
    parameter int SAMPLE_CYC = `ADSC_SAMPLE_CYC,
    parameter int BIT_CYC    = `ADSC_BIT_CYC
) (
    input  wire logic       clk_sys,   // system clock
    input  wire logic       rstn,      // sync reset, active low
    input  wire logic       start,     // begin a conversion (wins over abort)
    input  wire logic       abort,     // drop the conversion in flight
    input  wire logic       cmp_in,    // comparator: input at or above trial
    output logic            sample_en, // sampling switch closed
    output logic [9:0]      trial,     // trial code to the comparator dac
    output logic            done,      // one-cycle pulse, result valid
    output logic [9:0]      result     // finished conversion code
);

    adsc_sar_type s;
    adsc_sar_type next_s;
    logic [9:0]   kept;

    // ------------------------------------------------------------
    // next state: sample, then walk bits from msb down
    // ------------------------------------------------------------
    always_comb begin
        next_s = s;
        next_s.done = 1'b0;
        kept = s.trial;
        if (!cmp_in) begin
            kept[s.bit_idx] = 1'b0;
        end
        if (start) begin
            next_s.ph    = PH_SAMPLE;
            next_s.cnt   = 4'(SAMPLE_CYC - 1);
            next_s.trial = 10'h000;
        end else if (abort) begin
            next_s.ph    = PH_IDLE;
            next_s.trial = 10'h000;
        end else begin
            unique case (s.ph)
                PH_IDLE: begin
                end
                PH_SAMPLE: begin
                    if (s.cnt == 4'h0) begin
                        next_s.ph      = PH_BITS;
                        next_s.bit_idx = 4'h9;
                        next_s.trial   = 10'h200;
                        next_s.cnt     = 4'(BIT_CYC - 1);
                    end else begin
                        next_s.cnt = s.cnt - 4'h1;
                    end
                end
                PH_BITS: begin
                    if (s.cnt != 4'h0) begin
                        next_s.cnt = s.cnt - 4'h1;
                    end else if (s.bit_idx == 4'h0) begin
                        next_s.done   = 1'b1;
                        next_s.result = kept;
                        next_s.trial  = 10'h000;
                        next_s.ph     = PH_IDLE;
                    end else begin
                        next_s.trial = kept;
                        next_s.trial[s.bit_idx - 4'h1] = 1'b1;
                        next_s.bit_idx = s.bit_idx - 4'h1;
                        next_s.cnt     = 4'(BIT_CYC - 1);
                    end
                end
            endcase
        end
    end

    // ------------------------------------------------------------
    // state register
    // ------------------------------------------------------------
    always_ff @(posedge clk_sys) begin
        if (!rstn) begin
            s <= '{ph: PH_IDLE, cnt: 4'h0, bit_idx: 4'h0, trial: 10'h000,
                   result: 10'h000, done: 1'b0};
        end else begin
            s <= next_s;
        end
    end

    assign sample_en = (s.ph == PH_SAMPLE);
    assign trial     = s.trial;
    assign done      = s.done;
    assign result    = s.result;

endmodule

// ===== adsc_ctl.sv
// converter sequencer: mode and channel registers, start control,
// result store with its conflict handling, and the end flag
// assumes all inputs are synchronous to clk_sys; writes are one-cycle strobes
`timescale 1ns/1ps
`include "adsc_cfg.svh"

module adsc_ctl
    import adsc_pkg::*;
#(
    parameter int SETTLE_CYC = `ADSC_SETTLE_CYC
) (
    input  wire logic       clk_sys,            // system clock, 40 MHz
    input  wire logic       rstn,               // sync reset, active low
    input  wire logic       mode_wr,            // strobe: write mode register
    input  wire logic [7:0] mode_wdata,         // mode register write data
    input  wire logic       chan_wr,            // strobe: write channel select
    input  wire logic [2:0] chan_wdata,         // channel select write data
    input  wire logic       result_rd,          // strobe: read result
    input  wire logic       flag_clr,           // strobe: clear end flag
    input  wire logic       standby,            // chip standby level
    input  wire logic       trig_in,            // external trigger line
    input  wire logic       cmp_in,             // comparator decision
    input  wire logic [7:0] analog_pin_level,   // digital view of input pins
    output logic [7:0]      conv_mode_reg,      // mode register
    output logic [2:0]      channel_select_reg, // channel select register
    output logic [9:0]      conv_result_reg,    // result register
    output logic [9:0]      rd_data,            // data returned by a read
    output logic            conv_end_flag,      // sticky end flag
    output logic            conv_end_irq,       // one-cycle end request
    output logic            conv_busy,          // conversion in flight
    output logic            ref_string_on,      // reference string current
    output logic            sample_en,          // sampling switch closed
    output logic [9:0]      dac_trial,          // trial code to comparator
    output logic [7:0]      port_in_data,       // shared digital input port
    output logic            power_settled       // settle wait after power up
);

    adsc_ctl_type s;
    adsc_ctl_type next_s;
    logic         sar_start;
    logic         sar_abort;
    logic         sar_done;
    logic [9:0]   sar_result;
    logic         reg_wr;
    logic         halt;
    logic         trig_edge;
    logic         store;

    // ------------------------------------------------------------
    // trigger edge decode per selected edge
    // ------------------------------------------------------------
    function automatic logic edge_hit(input logic [1:0] sel, input logic prev,
                                      input logic cur);
        logic rise;
        logic fall;
        rise = cur & ~prev;
        fall = prev & ~cur;
        if (sel == `ADSC_EDGE_FALL) begin
            edge_hit = fall;
        end else if (sel == `ADSC_EDGE_RISE) begin
            edge_hit = rise;
        end else begin
            edge_hit = rise | fall;
        end
    endfunction

    // ------------------------------------------------------------
    // approximation engine
    // ------------------------------------------------------------
    adsc_sar u_sar (
        .clk_sys   (clk_sys),
        .rstn      (rstn),
        .start     (sar_start),
        .abort     (sar_abort),
        .cmp_in    (cmp_in),
        .sample_en (sample_en),
        .trial     (dac_trial),
        .done      (sar_done),
        .result    (sar_result)
    );

    // ------------------------------------------------------------
    // next state of the sequencer
    // ------------------------------------------------------------
    always_comb begin
        next_s    = s;
        next_s.irq = 1'b0;
        sar_start = 1'b0;
        reg_wr    = mode_wr | chan_wr;
        if (mode_wr) begin
            next_s.mode = mode_wdata;
        end
        if (chan_wr) begin
            next_s.chan = chan_wdata;
        end
        next_s.trig_prev = trig_in;
        next_s.port      = analog_pin_level;
        trig_edge = edge_hit(s.mode[`ADSC_MODE_EDGE_HI:`ADSC_MODE_EDGE_LO],
                             s.trig_prev, trig_in);
        // read samples the old value; a same-cycle store lands after it
        if (result_rd) begin
            next_s.rd_data = s.result;
        end
        // a register write in the store cycle kills the store
        store = sar_done & (s.st == ST_CONV) & ~reg_wr;
        if (store) begin
            next_s.result = sar_result;
            next_s.irq    = 1'b1;
            next_s.flag   = 1'b1;
        end else if (flag_clr) begin
            next_s.flag = 1'b0;
        end
        halt = standby | ~next_s.mode[`ADSC_MODE_RUN];
        sar_abort = (s.st == ST_CONV) & (reg_wr | halt);
        unique case (s.st)
            ST_IDLE: begin
                if (!halt) begin
                    if (next_s.mode[`ADSC_MODE_TRIG]) begin
                        next_s.st = ST_WAIT;
                    end else begin
                        sar_start = 1'b1;
                    end
                end
            end
            ST_WAIT: begin
                if (halt) begin
                    next_s.st = ST_IDLE;
                end else if (!next_s.mode[`ADSC_MODE_TRIG]) begin
                    sar_start = 1'b1;
                end else if (trig_edge && !reg_wr) begin
                    sar_start = 1'b1;
                end
            end
            ST_CONV: begin
                // trigger edges are never looked at here
                if (halt) begin
                    next_s.st = ST_IDLE;
                end else if (reg_wr || sar_done) begin
                    if (next_s.mode[`ADSC_MODE_TRIG]) begin
                        next_s.st = ST_WAIT;
                    end else begin
                        sar_start = 1'b1;
                    end
                end
            end
        endcase
        if (sar_start) begin
            next_s.st = ST_CONV;
        end
        // settle counter only reports; software owns the wait
        if (!next_s.mode[`ADSC_MODE_POWER]) begin
            next_s.settle_cnt = 10'h000;
            next_s.settled    = 1'b0;
        end else if (s.settle_cnt == 10'(SETTLE_CYC - 1)) begin
            next_s.settled = 1'b1;
        end else begin
            next_s.settle_cnt = s.settle_cnt + 10'h001;
        end
    end

    // ------------------------------------------------------------
    // state register
    // ------------------------------------------------------------
    always_ff @(posedge clk_sys) begin
        if (!rstn) begin
            s <= '{st: ST_IDLE, mode: `ADSC_MODE_RESET, chan: `ADSC_CHAN_RESET,
                   result: `ADSC_RESULT_RESET, rd_data: 10'h000, flag: 1'b0,
                   irq: 1'b0, trig_prev: 1'b0, port: 8'h00,
                   settle_cnt: 10'h000, settled: 1'b0};
        end else begin
            s <= next_s;
        end
    end

    // outputs straight from the state flops
    assign conv_mode_reg      = s.mode;
    assign channel_select_reg = s.chan;
    assign conv_result_reg    = s.result;
    assign rd_data            = s.rd_data;
    assign conv_end_flag      = s.flag;
    assign conv_end_irq       = s.irq;
    assign conv_busy          = s.st[2];
    assign ref_string_on      = s.mode[`ADSC_MODE_RUN];
    assign port_in_data       = s.port;
    assign power_settled      = s.settled;

    // ------------------------------------------------------------
    // checks
    // ------------------------------------------------------------
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (!rstn);

    sequence seq_end_clean;
        conv_busy && sar_done && !mode_wr && !chan_wr;
    endsequence
    sequence seq_keep_running;
        conv_mode_reg[7] && !standby;
    endsequence

    AST_STORE_IRQ: assert property (seq_end_clean |=> conv_end_irq &&
        conv_result_reg == $past(sar_result)) else $error("store without irq");
    AST_SW_B2B: assert property (seq_end_clean and seq_keep_running and
        !conv_mode_reg[6] |=> conv_busy ##1 sample_en) else $error("no restart");
    AST_HW_WAIT: assert property (seq_end_clean and seq_keep_running and
        conv_mode_reg[6] |=> !conv_busy) else $error("hw started unbidden");
    AST_WR_ABORT: assert property ((conv_busy && chan_wr && !mode_wr &&
        !conv_mode_reg[6]) and seq_keep_running |=> ##1 sample_en)
        else $error("write did not restart");
    // a lifted halt may restart at once, so only the first cycle is checked
    AST_STOP: assert property ((mode_wr && !mode_wdata[7]) || standby |=>
        !conv_busy && !sample_en && dac_trial == 10'h000)
        else $error("conversion not halted");
    AST_READ_OLD: assert property (result_rd |=>
        rd_data == $past(conv_result_reg)) else $error("read got new data");
    AST_TRIG_IGNORE: assert property ((conv_busy && !sar_done && !mode_wr &&
        !chan_wr) and seq_keep_running |=> conv_busy && !$rose(sample_en))
        else $error("trigger restarted conversion");
    AST_WR_WINS: assert property (conv_busy && sar_done && (mode_wr || chan_wr)
        |=> !conv_end_irq && $stable(conv_result_reg)) else $error("store won");
    AST_FLAG_KEEP: assert property (conv_end_flag && !flag_clr |=>
        conv_end_flag) else $error("flag dropped");
    AST_FLAG_SET: assert property (conv_end_irq |-> conv_end_flag)
        else $error("irq without flag");

endmodule

// ===== adsc_cmp_model.sv
// comparator stand-in for the analog front end of the converter
// assumes the bench gives the pin level as an ideal 10-bit code
`timescale 1ns/1ps

module adsc_cmp_model #(
    parameter int LAG = 0             // 0 answers at once, 1 one clock late
) (
    input  wire logic       clk_sys,   // system clock
    input  wire logic       sample_en, // sampling switch closed
    input  wire logic [9:0] dac_trial, // trial code from the engine
    input  wire logic [9:0] vin_code,  // pin level as an ideal code
    output logic            cmp_in     // 1 while held level >= trial
);
    // ------------------------------------------------------------
    // sample and hold, then compare
    // ------------------------------------------------------------
    logic [9:0] held;                 // charge on the sampling capacitor
    logic       late;                 // answer of the slow comparator

    // only the sample phase charges the cap, later pin moves are unseen
    always_ff @(posedge clk_sys) begin
        if (sample_en) begin
            held <= vin_code;
        end
        late <= (held >= dac_trial);
    end

    // the late answer lets a test show a slow settling comparator
    assign cmp_in = (LAG != 0) ? late : (held >= dac_trial);
endmodule

// ===== testbench.sv
// self-checking bench for the converter sequencer
// assumes adsc_cfg.svh on the include path; comparator is a behavioural model
`timescale 1ns/1ps

module testbench;
    import adsc_pkg::*;

    // ------------------------------------------------------------
    // signals
    // ------------------------------------------------------------
    logic       clk_sys, rstn, mode_wr, chan_wr, result_rd, flag_clr;
    logic       standby, trig_in, cmp_in;
    logic [7:0] mode_wdata, analog_pin_level, conv_mode_reg, port_in_data;
    logic [2:0] chan_wdata, channel_select_reg;
    logic [9:0] conv_result_reg, rd_data, dac_trial, vin;
    logic       conv_end_flag, conv_end_irq, conv_busy, ref_string_on;
    logic       sample_en, power_settled;
    int         errors, cmp_count, p, n, sc;

    adsc_ctl #(.SETTLE_CYC(4)) dut (
        .clk_sys(clk_sys), .rstn(rstn), .mode_wr(mode_wr), .mode_wdata(mode_wdata),
        .chan_wr(chan_wr), .chan_wdata(chan_wdata), .result_rd(result_rd),
        .flag_clr(flag_clr), .standby(standby), .trig_in(trig_in), .cmp_in(cmp_in),
        .analog_pin_level(analog_pin_level), .conv_mode_reg(conv_mode_reg),
        .channel_select_reg(channel_select_reg), .conv_result_reg(conv_result_reg),
        .rd_data(rd_data), .conv_end_flag(conv_end_flag), .conv_end_irq(conv_end_irq),
        .conv_busy(conv_busy), .ref_string_on(ref_string_on), .sample_en(sample_en),
        .dac_trial(dac_trial), .port_in_data(port_in_data), .power_settled(power_settled)
    );

    adsc_cmp_model #(.LAG(0)) cmp (
        .clk_sys(clk_sys), .sample_en(sample_en), .dac_trial(dac_trial),
        .vin_code(vin), .cmp_in(cmp_in)
    );

    // 40 MHz clock
    initial begin
        clk_sys = 1'b0;
        forever #12.5 clk_sys = ~clk_sys;
    end

    // sampling cycles seen since the last clear
    always @(posedge clk_sys) begin
        if (sample_en === 1'b1) sc++;
    end

    // ------------------------------------------------------------
    // compare, report and access tasks
    // ------------------------------------------------------------
    task automatic chk_val(input string what, input logic [9:0] exp, input logic [9:0] got);
        cmp_count++;
        if (got !== exp) begin
            errors++;
            $display("Error %s expected %h seen %h", what, exp, got);
        end
    endtask

    task automatic chk_bit(input string what, input logic exp, input logic got);
        cmp_count++;
        if (got !== exp) begin
            errors++;
            $display("Error %s expected %b seen %b", what, exp, got);
        end
    endtask

    task automatic finish_test();
        $display("comparisons %0d mismatches %0d", cmp_count, errors);
        if (errors == 0 && cmp_count > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask

    task automatic wr_mode(input logic [7:0] v);
        @(posedge clk_sys);
        mode_wr    <= 1'b1;
        mode_wdata <= v;
        @(posedge clk_sys);
        mode_wr    <= 1'b0;
    endtask

    task automatic wr_chan(input logic [2:0] v);
        @(posedge clk_sys);
        chan_wr    <= 1'b1;
        chan_wdata <= v;
        @(posedge clk_sys);
        chan_wr    <= 1'b0;
    endtask

    task automatic clr_flag();
        @(posedge clk_sys);
        flag_clr <= 1'b1;
        @(posedge clk_sys);
        flag_clr <= 1'b0;
    endtask

    // bounded wait for the end request; a hang closes the run
    task automatic wait_irq(input int lim, output int cnt);
        cnt = 0;
        do begin
            @(posedge clk_sys);
            #1 cnt++;
        end while (conv_end_irq !== 1'b1 && cnt < lim);
        if (conv_end_irq !== 1'b1) begin
            errors++;
            $display("Error conv_end_irq expected 1 seen %b", conv_end_irq);
            finish_test();
        end else begin
            chk_bit("conv_end_flag", 1'b1, conv_end_flag);
        end
    endtask

    // counts end requests over a quiet stretch
    task automatic quiet(input int cyc, output int hits);
        hits = 0;
        repeat (cyc) begin
            @(posedge clk_sys);
            #1 if (conv_end_irq === 1'b1) hits++;
        end
    endtask

    // ------------------------------------------------------------
    // main sequence
    // ------------------------------------------------------------
    initial begin
        errors = 0; cmp_count = 0; sc = 0;
        rstn = 1'b0; mode_wr = 1'b0; chan_wr = 1'b0; result_rd = 1'b0;
        flag_clr = 1'b0; standby = 1'b0; trig_in = 1'b0; vin = 10'h2a5;
        mode_wdata = 8'h00; chan_wdata = 3'h0; analog_pin_level = 8'h00;
        repeat (3) @(posedge clk_sys);
        rstn <= 1'b1;
        #1 chk_val("conv_result_reg", 10'h000, conv_result_reg);
        chk_bit("conv_end_flag", 1'b0, conv_end_flag);
        // power first, then wait out the settle time before running
        wr_mode(8'h01);
        #1 chk_val("conv_mode_reg", 10'h001, {2'h0, conv_mode_reg});
        repeat (8) @(posedge clk_sys);
        #1 chk_bit("power_settled", 1'b1, power_settled);
        $display("test reset_power done");

        // software start, back to back, sample phase length
        wr_chan(3'h5);
        wr_mode(8'h81);
        #1 chk_bit("ref_string_on", 1'b1, ref_string_on);
        wait_irq(60, n);
        chk_val("conv_result_reg", 10'h2a5, conv_result_reg);
        vin = 10'h3ff;
        sc = 0;
        wait_irq(60, p);
        chk_val("conv_result_reg", 10'h3ff, conv_result_reg);
        chk_val("sample cycles", 10'h002, sc[9:0]);
        $display("test sw_run done");

        // read in the store cycle gets the old value first
        vin = 10'h000;
        repeat (p - 1) @(posedge clk_sys);
        result_rd <= 1'b1;
        @(posedge clk_sys);
        result_rd <= 1'b0;
        #1 chk_val("rd_data", 10'h3ff, rd_data);
        chk_val("conv_result_reg", 10'h000, conv_result_reg);
        chk_bit("conv_end_irq", 1'b1, conv_end_irq);

        // mode write in the store cycle wins and restarts
        vin = 10'h155;
        repeat (p - 1) @(posedge clk_sys);
        mode_wr    <= 1'b1;
        mode_wdata <= 8'h81;
        @(posedge clk_sys);
        mode_wr <= 1'b0;
        #1 chk_bit("conv_end_irq", 1'b0, conv_end_irq);
        chk_val("conv_result_reg", 10'h000, conv_result_reg);
        wait_irq(p + 10, n);
        chk_val("conv_result_reg", 10'h155, conv_result_reg);
        $display("test conflicts done");

        // channel rewrite right after a store keeps flag and result
        wr_chan(3'h2);
        #1 chk_bit("conv_end_flag", 1'b1, conv_end_flag);
        chk_val("conv_result_reg", 10'h155, conv_result_reg);
        chk_val("channel_select_reg", 10'h002, {7'h00, channel_select_reg});
        // channel rewrite mid conversion aborts and restarts
        vin = 10'h0aa;
        repeat (8) @(posedge clk_sys);
        wr_chan(3'h3);
        wait_irq(p + 10, n);
        chk_bit("late store after abort", 1'b1, n >= p - 3);
        chk_val("conv_result_reg", 10'h0aa, conv_result_reg);
        $display("test abort done");

        // stop clears the reference string, flag clears by software
        wr_mode(8'h01);
        repeat (2) @(posedge clk_sys);
        #1 chk_bit("conv_busy", 1'b0, conv_busy);
        chk_bit("ref_string_on", 1'b0, ref_string_on);
        chk_val("conv_result_reg", 10'h0aa, conv_result_reg);
        clr_flag();
        #1 chk_bit("conv_end_flag", 1'b0, conv_end_flag);
        quiet(p + 5, n);
        chk_val("stopped stores", 10'h000, n[9:0]);
        // standby halts a running conversion
        wr_mode(8'h81);
        repeat (5) @(posedge clk_sys);
        standby <= 1'b1;
        repeat (2) @(posedge clk_sys);
        #1 chk_bit("conv_busy", 1'b0, conv_busy);
        quiet(p + 5, n);
        chk_val("standby stores", 10'h000, n[9:0]);
        standby <= 1'b0;
        wr_mode(8'h01);
        clr_flag();
        $display("test stop_standby done");

        // hardware start on rising edges, edges while busy ignored
        wr_mode(8'hc3);
        repeat (3) @(posedge clk_sys);
        vin = 10'h301;
        trig_in <= 1'b1;
        repeat (4) @(posedge clk_sys);
        trig_in <= 1'b0;
        repeat (3) @(posedge clk_sys);
        trig_in <= 1'b1;
        wait_irq(p + 10, n);
        chk_val("conv_result_reg", 10'h301, conv_result_reg);
        // a restart on the busy edge would push the store 7 cycles later
        chk_val("trigger to store", 10'h011, n[9:0]);
        quiet(2 * p, n);
        chk_val("untriggered stores", 10'h000, n[9:0]);
        vin = 10'h0f0;
        @(posedge clk_sys);
        trig_in <= 1'b0;
        @(posedge clk_sys);
        trig_in <= 1'b1;
        wait_irq(p + 10, n);
        chk_val("conv_result_reg", 10'h0f0, conv_result_reg);
        wr_mode(8'h01);
        $display("test hw_start done");

        // shared digital port, sampled in every state, read here while idle
        analog_pin_level <= 8'h5a;
        repeat (2) @(posedge clk_sys);
        #1 chk_val("port_in_data", 10'h05a, {2'h0, port_in_data});
        chk_val("dac_trial", 10'h000, dac_trial);
        $display("test port done");
        finish_test();
    end
endmodule
